/* File: core_slice_pkg.sv */
// constants, field positions and codes for the reset, pc and file-op core slice
// assumes a 32-bit AXI4-Lite register bus with byte addresses in the low 8 bits
`default_nettype none

package core_slice_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PC_W = 13;
  localparam int unsigned FILE_DEPTH = 128;

  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_EVENT = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PCSTAT = 8'h14;
  localparam logic [7:0] OFF_PCLATCH = 8'h18;
  localparam logic [7:0] OFF_WREG = 8'h1c;
  localparam logic [7:0] OFF_FADDR = 8'h20;
  localparam logic [7:0] OFF_FDATA = 8'h24;
  localparam logic [7:0] OFF_CYCLES = 8'h28;

  // reset values
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [1:0] PCSTAT_POR = 2'h0;

  // field positions
  localparam int unsigned TO_BIT = 4;
  localparam int unsigned PD_BIT = 3;
  localparam int unsigned Z_BIT = 2;
  localparam int unsigned BOR_FLAG_BIT = 0;
  localparam int unsigned POR_FLAG_BIT = 1;
  localparam int unsigned GIE_BIT = 0;
  localparam int unsigned SLEEP_BIT = 1;
  localparam int unsigned BUSY_BIT = 2;

  // opcode fields of the 14-bit instruction word
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECREMENT = 6'h03;
  localparam logic [5:0] OPC_INCREMENT = 6'h0a;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [2:0] OPC_BRANCH = 3'h5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0]
  {
    EV_POR = 3'h0,
    EV_EXTERNAL_MASTER_CLEAR = 3'h1,
    EV_WDT = 3'h2,
    EV_BOR = 3'h3,
    EV_INT = 3'h4
  } event_t;

  typedef enum logic
  {
    ST_IDLE = 1'b0,
    ST_SECOND = 1'b1
  } state_t;

endpackage : core_slice_pkg

`default_nettype wire

/* File: core_reset_pc_file_ops.sv */
// core slice: reset and wake-up handling of pc, status and power status, plus file ops
// assumes an AXI4-Lite master on the same clock; reset events and instructions arrive by register writes
//
// Notes on behaviour
// RULE_01: a power-on reset zeroes the pc, sets status to 0001 1000 and clears both power status flags.
// RULE_02: an external_master_clear reset while running zeroes the pc and status bits 7:5 only.
// RULE_03: an external_master_clear reset in sleep zeroes the pc and bits 7:5, sets timeout_flag, clears powerdown_flag.
// RULE_04: an interrupt wake-up goes on at pc plus one, sets timeout_flag and clears powerdown_flag.
// RULE_05: watchdog_timer reset, watchdog_timer wake-up and brown_out reset each load pc, status and flags as tabled.
// RULE_06: an interrupt wake-up with global_interrupt_enable set loads the pc with the interrupt vector.
// RULE_07: complement_file_op inverts a file register and writes it to w or the file, updating zero_flag.
// RULE_08: decrement_file_op subtracts one and writes to w or the file, updating zero_flag.
// RULE_09: increment_file_op adds one and writes to w or the file, updating zero_flag.
// RULE_10: branch_absolute_op loads pc from an 11-bit immediate and pc_high_latch bits 4:3 in two cycles.
// RULE_11: decrement_skip_zero_op writes without touching flags and skips the next slot on a zero result.
// RULE_12: increment_skip_zero_op writes without touching flags and skips the next slot on a zero result.
// RULE_13: timeout_flag and powerdown_flag are set per reset source so software can tell them apart.
// RULE_14: power status bit 0 is the brown-out flag, bit 1 the power-on flag.
// RULE_15: zero_flag is set when the 8-bit result is zero and cleared otherwise.
// RULE_16: any other instruction advances the pc by one in a single cycle.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module core_reset_pc_file_ops (
  input wire logic clock,
  input wire logic rst,
  input wire logic [core_slice_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [core_slice_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [core_slice_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [core_slice_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import core_slice_pkg::*;

  logic [ADDR_W-1:0] awAddr_q;
  logic awHeld_q;
  logic [DATA_W-1:0] wData_q;
  logic [3:0] wStrb_q;
  logic wHeld_q;
  logic wrFire;
  logic regWr;
  logic eventFire;
  logic issue;
  logic [2:0] evCode;

  logic [12:0] pc_q;
  logic [7:0] status_q;
  logic [1:0] pcStat_q;
  logic [7:0] wAcc_q;
  logic [4:0] pcLatch_q;
  logic [6:0] fAddr_q;
  logic gie_q;
  logic asleep_q;
  logic skip_q;
  logic [13:0] lastInstr_q;
  logic [31:0] cycles_q;
  state_t state_q;
  logic [7:0] fileMem [FILE_DEPTH];

  logic [13:0] opWord;
  logic [6:0] opAddr;
  logic opDest;
  logic [7:0] operand;
  logic [7:0] result;
  logic isFileOp;
  logic isBranch;
  logic updZero;
  logic skipOnZero;
  logic [DATA_W-1:0] readData;
  logic readHit;

  assign wrFire = awHeld_q && wHeld_q && !bvalid;
  assign regWr = wrFire && wStrb_q[0];
  assign evCode = wData_q[2:0];
  assign eventFire = regWr && (awAddr_q == OFF_EVENT);
  assign opWord = wData_q[13:0];
  assign opAddr = opWord[6:0];
  assign opDest = opWord[7];
  assign operand = fileMem[opAddr];
  // instructions are refused while busy or asleep
  assign issue = wrFire && (wStrb_q[1:0] == 2'h3) && (awAddr_q == OFF_INSTR) && (state_q == ST_IDLE) && !asleep_q;

  // write address and data capture, either order
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awHeld_q <= 1'b0;
      awAddr_q <= '0;
      awready <= 1'b1;
    end
    else if (awvalid && awready)
    begin
      awHeld_q <= 1'b1;
      awAddr_q <= awaddr;
      awready <= 1'b0;
    end
    else
    begin
      if (wrFire)
        awHeld_q <= 1'b0;
      if (bvalid && bready)
        awready <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wHeld_q <= 1'b0;
      wData_q <= '0;
      wStrb_q <= '0;
      wready <= 1'b1;
    end
    else if (wvalid && wready)
    begin
      wHeld_q <= 1'b1;
      wData_q <= wdata;
      wStrb_q <= wstrb;
      wready <= 1'b0;
    end
    else
    begin
      if (wrFire)
        wHeld_q <= 1'b0;
      if (bvalid && bready)
        wready <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else if (wrFire)
    begin
      bvalid <= 1'b1;
      bresp <= (awAddr_q <= OFF_CYCLES && awAddr_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // instruction decode
  always_comb
  begin
    result = operand;
    isFileOp = 1'b0;
    updZero = 1'b0;
    skipOnZero = 1'b0;
    isBranch = (opWord[13:11] == OPC_BRANCH);
    case (opWord[13:8])
      // RULE_07 complement result
      OPC_COMPLEMENT:
      begin
        result = ~operand;
        isFileOp = 1'b1;
        updZero = 1'b1;
      end
      // RULE_08 decrement result
      OPC_DECREMENT:
      begin
        result = operand - 8'h01;
        isFileOp = 1'b1;
        updZero = 1'b1;
      end
      // RULE_09 increment result
      OPC_INCREMENT:
      begin
        result = operand + 8'h01;
        isFileOp = 1'b1;
        updZero = 1'b1;
      end
      OPC_DEC_SKIP:
      begin
        result = operand - 8'h01;
        isFileOp = 1'b1;
        skipOnZero = 1'b1;
      end
      OPC_INC_SKIP:
      begin
        result = operand + 8'h01;
        isFileOp = 1'b1;
        skipOnZero = 1'b1;
      end
      default:
        result = operand;
    endcase
  end

  // file register array, written by file ops and by software
  always_ff @(posedge clock)
  begin
    if (issue && isFileOp && opDest)
      fileMem[opAddr] <= result;
    else if (regWr && awAddr_q == OFF_FDATA)
      fileMem[fAddr_q] <= wData_q[7:0];
  end

  // pc, status, power status and execution sequencing
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pc_q <= PC_RESET;
      status_q <= STATUS_POR;
      pcStat_q <= PCSTAT_POR;
      wAcc_q <= '0;
      pcLatch_q <= '0;
      fAddr_q <= '0;
      gie_q <= 1'b0;
      asleep_q <= 1'b0;
      skip_q <= 1'b0;
      state_q <= ST_IDLE;
      lastInstr_q <= '0;
      cycles_q <= '0;
    end
    else if (eventFire)
    begin
      state_q <= ST_IDLE;
      skip_q <= 1'b0;
      // RULE_13 flags by source
      case (evCode)
        EV_POR:
        begin
          // RULE_01 power-on load
          pc_q <= PC_RESET;
          status_q <= STATUS_POR;
          // RULE_14 flag positions
          pcStat_q <= PCSTAT_POR;
          asleep_q <= 1'b0;
        end
        EV_EXTERNAL_MASTER_CLEAR:
        begin
          pc_q <= PC_RESET;
          asleep_q <= 1'b0;
          // RULE_03 sleep master clear
          if (asleep_q)
            status_q <= {3'h0, 1'b1, 1'b0, status_q[2:0]};
          // RULE_02 running master clear
          else
            status_q <= {3'h0, status_q[4:0]};
        end
        EV_WDT:
        begin
          asleep_q <= 1'b0;
          // RULE_05 watchdog wake or reset
          if (asleep_q)
          begin
            pc_q <= pc_q + 13'h0001;
            status_q <= {status_q[7:5], 2'h0, status_q[2:0]};
          end
          else
          begin
            pc_q <= PC_RESET;
            status_q <= {3'h0, 1'b0, 1'b1, status_q[2:0]};
          end
        end
        EV_BOR:
        begin
          // RULE_05 brown-out reset
          pc_q <= PC_RESET;
          status_q <= {3'h0, 1'b1, 1'b1, status_q[2:0]};
          pcStat_q[BOR_FLAG_BIT] <= 1'b0;
          asleep_q <= 1'b0;
        end
        EV_INT:
        begin
          // RULE_04 interrupt wake-up
          if (asleep_q)
          begin
            asleep_q <= 1'b0;
            status_q <= {status_q[7:5], 1'b1, 1'b0, status_q[2:0]};
            // RULE_06 vector redirect
            pc_q <= gie_q ? INT_VECTOR : pc_q + 13'h0001;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
    else
    begin
      if (state_q == ST_SECOND)
      begin
        state_q <= ST_IDLE;
        cycles_q <= cycles_q + 32'h1;
        // RULE_11 skipped slot as no_operation
        if (skip_q)
          pc_q <= pc_q + 13'h0001;
        skip_q <= 1'b0;
      end
      if (issue)
      begin
        lastInstr_q <= opWord;
        cycles_q <= cycles_q + 32'h1;
        if (isBranch)
        begin
          // RULE_10 absolute branch
          pc_q <= {pcLatch_q[4:3], opWord[10:0]};
          state_q <= ST_SECOND;
        end
        else
        begin
          // RULE_16 single-cycle advance
          pc_q <= pc_q + 13'h0001;
          // RULE_12 skip on zero
          if (skipOnZero && result == 8'h00)
          begin
            state_q <= ST_SECOND;
            skip_q <= 1'b1;
          end
        end
        // RULE_07 destination select
        if (isFileOp && !opDest)
          wAcc_q <= result;
        // RULE_15 zero flag
        if (updZero)
          status_q[Z_BIT] <= (result == 8'h00);
      end
      if (regWr)
      begin
        case (awAddr_q)
          OFF_CTRL:
          begin
            gie_q <= wData_q[GIE_BIT];
            if (wData_q[SLEEP_BIT])
              asleep_q <= 1'b1;
          end
          OFF_STATUS: status_q <= {wData_q[7:5], status_q[4:3], wData_q[2:0]};
          OFF_PCSTAT: pcStat_q <= wData_q[1:0];
          OFF_PCLATCH: pcLatch_q <= wData_q[4:0];
          OFF_WREG: wAcc_q <= wData_q[7:0];
          OFF_FADDR: fAddr_q <= wData_q[6:0];
          default: fAddr_q <= fAddr_q;
        endcase
      end
    end
  end

  // read data select
  always_comb
  begin
    readData = '0;
    readHit = 1'b1;
    case (araddr)
      OFF_INSTR: readData = {18'h0, lastInstr_q};
      OFF_EVENT: readData = '0;
      OFF_CTRL: readData = {29'h0, (state_q == ST_SECOND), asleep_q, gie_q};
      OFF_PC: readData = {19'h0, pc_q};
      OFF_STATUS: readData = {24'h0, status_q};
      OFF_PCSTAT: readData = {30'h0, pcStat_q};
      OFF_PCLATCH: readData = {27'h0, pcLatch_q};
      OFF_WREG: readData = {24'h0, wAcc_q};
      OFF_FADDR: readData = {25'h0, fAddr_q};
      OFF_FDATA: readData = {24'h0, fileMem[fAddr_q]};
      OFF_CYCLES: readData = cycles_q;
      default: readHit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= readData;
      rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_por_event_load: assert property ( // RULE_01
    eventFire && evCode == EV_POR |=> pc_q == PC_RESET && status_q == STATUS_POR && pcStat_q == PCSTAT_POR)
    else $error("power-on event did not load pc, status and power flags");

  a_external_master_clear_run_keep: assert property ( // RULE_02
    eventFire && evCode == EV_EXTERNAL_MASTER_CLEAR && !asleep_q
    |=> pc_q == PC_RESET && status_q[7:5] == 3'h0 && status_q[4:0] == $past(status_q[4:0])
        && pcStat_q == $past(pcStat_q))
    else $error("running master clear changed the wrong bits");

  a_external_master_clear_sleep_flags: assert property ( // RULE_03
    eventFire && evCode == EV_EXTERNAL_MASTER_CLEAR && asleep_q
    |=> pc_q == PC_RESET && status_q[7:3] == 5'h02 && status_q[2:0] == $past(status_q[2:0]) && !asleep_q)
    else $error("master clear in sleep gave a wrong status");

  a_int_wake_next: assert property ( // RULE_04
    eventFire && evCode == EV_INT && asleep_q && !gie_q
    |=> pc_q == $past(pc_q) + 13'h0001 && status_q[TO_BIT] && !status_q[PD_BIT])
    else $error("interrupt wake-up did not continue at the next address");

  a_int_vector_load: assert property ( // RULE_06
    eventFire && evCode == EV_INT && asleep_q && gie_q |=> pc_q == INT_VECTOR)
    else $error("interrupt wake-up with enable set missed the vector");

  a_wdt_reset_flags: assert property ( // RULE_05
    eventFire && evCode == EV_WDT && !asleep_q |=> pc_q == PC_RESET && status_q[7:3] == 5'h01)
    else $error("watchdog reset gave a wrong status");

  a_branch_two_cycles: assert property ( // RULE_10
    issue && isBranch
    |=> pc_q == {$past(pcLatch_q[4:3]), $past(opWord[10:0])} && state_q == ST_SECOND
    ##1 state_q == ST_IDLE && $stable(pc_q))
    else $error("branch target or cycle count wrong");

  a_zero_flag_update: assert property ( // RULE_15
    issue && updZero |=> status_q[Z_BIT] == ($past(result) == 8'h00))
    else $error("zero flag does not follow the result");

  a_skip_adds_slot: assert property ( // RULE_11
    issue && skipOnZero && result == 8'h00
    |=> state_q == ST_SECOND && status_q == $past(status_q) ##1 pc_q == $past(pc_q, 2) + 13'h0002)
    else $error("zero result did not skip the next slot");

  a_plain_advance: assert property ( // RULE_16
    issue && !isBranch && !(skipOnZero && result == 8'h00) |=> pc_q == $past(pc_q) + 13'h0001 && state_q == ST_IDLE)
    else $error("single-cycle instruction did not advance by one");

  a_w_destination: assert property ( // RULE_08
    issue && isFileOp && !opDest |=> wAcc_q == $past(result))
    else $error("result missed the working accumulator");

  c_branch_taken: cover property (issue && isBranch ##2 state_q == ST_IDLE);
  c_skip_zero: cover property (issue && skipOnZero && result == 8'h00);
  c_vector_wake: cover property (eventFire && evCode == EV_INT && asleep_q && gie_q);
  c_brown_out: cover property (eventFire && evCode == EV_BOR);

endmodule : core_reset_pc_file_ops

`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the reset, pc and file-op core slice
// assumes the design answers AXI4-Lite on the one clock and holds its own assertions
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checksDone++; if ((g) !== 32'(e)) begin failures++; $display("mismatch %s expected %h seen %h", nm, 32'(e), g); end end

module tb_top;
  import core_slice_pkg::*;

  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  int failures = 0;
  int checksDone = 0;
  int cycleCount = 0;
  int seed = 64507;
  // behavioural model state
  int pc = 0;
  int st = 'h18;
  int pcs = 0;
  int w = 0;
  int cyc = 0;
  logic [5:0] opcs [5] = '{OPC_COMPLEMENT, OPC_DECREMENT, OPC_INCREMENT, OPC_DEC_SKIP, OPC_INC_SKIP};

  core_reset_pc_file_ops i_core_reset_pc_file_ops (.clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial
  begin
    forever #4 clock = ~clock;
  end

  task automatic wrap_up();
    if (failures == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge clock)
  begin
    cycleCount++;
    if (cycleCount == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    r = 2'h3;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        bready <= 1'b0;
        n = 1000;
      end
    end
    if (n < 1000) failures++;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    d = 32'hx;
    r = 2'h3;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100)
    begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        n = 1000;
      end
    end
    if (n < 1000) failures++;
  endtask : axiRead

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axiWrite(a, d, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input int e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(a, d, r);
    `CHK(nm, e, d)
    `CHK("rresp", RESP_OKAY, r)
  endtask : rdChk

  task automatic checkRegs();
    rdChk(OFF_PC, pc, "pc");
    rdChk(OFF_STATUS, st, "status");
    rdChk(OFF_PCSTAT, pcs, "power status");
  endtask : checkRegs

  task automatic branchTo(input int latch, input int imm);
    wr(OFF_PCLATCH, 32'(latch));
    wr(OFF_INSTR, {18'h0, OPC_BRANCH, 11'(imm)});
    pc = ((latch & 'h18) << 8) | imm;
    cyc += 2;
  endtask : branchTo

  task automatic doOp(input int op, input int f, input int d, input int v);
    int res;
    wr(OFF_FADDR, 32'(f));
    wr(OFF_FDATA, 32'(v));
    w = $random(seed) & 255;
    wr(OFF_WREG, 32'(w));
    wr(OFF_INSTR, {18'h0, opcs[op], 1'(d), 7'(f)});
    res = (op == 0) ? (~v & 255) : (op == 1 || op == 3) ? ((v - 1) & 255) : ((v + 1) & 255);
    if (d == 0) w = res;
    else v = res;
    if (op < 3) st = (res == 0) ? (st | 'h04) : (st & 'hfb);
    pc = (pc + ((op >= 3 && res == 0) ? 2 : 1)) & 'h1fff;
    cyc += (op >= 3 && res == 0) ? 2 : 1;
    rdChk(OFF_WREG, w, "working accumulator");
    rdChk(OFF_FDATA, v, "file data");
    rdChk(OFF_STATUS, st, "status zero");
    rdChk(OFF_PC, pc, "pc after op");
  endtask : doOp

  task automatic event_(input int code, input int newPc, input int newSt, input int newPcs);
    wr(OFF_EVENT, 32'(code));
    pc = newPc;
    st = newSt;
    pcs = newPcs;
  endtask : event_

  initial
  begin : mainSeq
    logic [31:0] d;
    logic [1:0] r;
    int v;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    checkRegs();
    // unmapped and misaligned places refuse
    axiWrite(8'h2c, 32'h5a, r);
    `CHK("bresp unmapped", RESP_SLVERR, r)
    axiWrite(8'h02, 32'h5a, r);
    `CHK("bresp misaligned", RESP_SLVERR, r)
    axiRead(8'h30, d, r);
    `CHK("rresp unmapped", RESP_SLVERR, r)
    `CHK("rdata unmapped", 0, d)
    // status write keeps the reset-source flags
    wr(OFF_STATUS, 32'hff);
    st = (st & 'h18) | 'he7;
    rdChk(OFF_STATUS, st, "status write");
    // file ops with zero results and both destinations
    for (int i = 0; i < 30; i++)
    begin
      v = $random(seed) & 255;
      if (i % 3 == 0) v = ((i % 5) == 1 || (i % 5) == 3) ? 1 : 255;
      doOp(i % 5, (i == 0) ? 127 : ($random(seed) & 127), (i / 5) % 2, v);
    end
    rdChk(OFF_CYCLES, cyc, "cycle count ops");
    for (int i = 0; i < 4; i++)
    begin
      branchTo($random(seed) & 31, (i == 0) ? 2047 : (i == 1) ? 0 : ($random(seed) & 2047));
      rdChk(OFF_PC, pc, "pc branch");
      rdChk(OFF_STATUS, st, "status branch");
    end
    rdChk(OFF_CYCLES, cyc, "cycle count branch");
    // instruction write without both low strobes is dropped
    wstrb <= 4'h1;
    wr(OFF_INSTR, {18'h0, OPC_INCREMENT, 8'h00});
    wstrb <= 4'hf;
    checkRegs();
    rdChk(OFF_CYCLES, cyc, "cycle count partial strobe");
    wr(OFF_PCSTAT, 32'h3);
    event_(EV_EXTERNAL_MASTER_CLEAR, 0, st & 'h1f, 3);
    checkRegs();
    // master clear in sleep, dropped instruction
    branchTo(0, 'h123);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_INSTR, {18'h0, OPC_INCREMENT, 8'h00});
    event_(EV_EXTERNAL_MASTER_CLEAR, 0, (st & 7) | 'h10, pcs);
    checkRegs();
    rdChk(OFF_CTRL, 0, "awake after reset");
    event_(EV_WDT, 0, (st & 7) | 'h08, pcs);
    checkRegs();
    branchTo(8, 'h055);
    wr(OFF_CTRL, 32'h2);
    event_(EV_WDT, pc + 1, st & 'he7, pcs);
    checkRegs();
    // interrupt while awake changes nothing
    event_(EV_INT, pc, st, pcs);
    checkRegs();
    branchTo(0, 'h200);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_INSTR, {18'h0, OPC_INCREMENT, 8'h00});
    event_(EV_INT, pc + 1, (st & 'he7) | 'h10, pcs);
    checkRegs();
    branchTo(0, 'h300);
    wr(OFF_CTRL, 32'h3);
    event_(EV_INT, 'h4, (st & 'he7) | 'h10, pcs);
    checkRegs();
    rdChk(OFF_CTRL, 1, "awake after interrupt");
    event_(EV_BOR, 0, (st & 7) | 'h18, pcs & 2);
    checkRegs();
    event_(EV_POR, 0, 'h18, 0);
    checkRegs();
    rdChk(OFF_CYCLES, cyc, "cycle count end");
    wrap_up();
  end

endmodule : tb_top

`undef CHK
`default_nettype wire
